// *** rwt_pkg.sv ***
// Shared constants and carriers of the reset, watchdog and timer block.
package rwt_pkg;
    localparam logic [6:0] TIMER_COUNT_ADDR = 7'h01;
    localparam logic [6:0] CORE_STATUS_ADDR = 7'h03;
    localparam logic [3:0] SYSCTL_CTRL_ADDR = 4'he;
    localparam int         CHANGE_WAKE_BIT  = 7;
    localparam int         TIMEOUT_BIT      = 4;
    localparam int         POWERDOWN_BIT    = 3;
    localparam logic [7:0] STATUS_WR_MASK   = 8'h67;
    localparam logic [7:0] STATUS_POR       = 8'h18;
    localparam int         SRC_SEL_BIT      = 5;
    localparam int         EDGE_SEL_BIT     = 4;
    localparam int         ASSIGN_BIT       = 3;
    localparam logic [7:0] TIMER_MODE_RST   = 8'h3f;
    localparam logic [7:0] PRESCALER_RST    = 8'hff;
    localparam int         WDT_ENABLE_BIT   = 7;
    localparam int         LV_ENABLE_BIT    = 5;
    localparam logic [7:0] SYSCTL_RST       = 8'ha0;
    localparam logic [7:0] SYSCTL_WR_MASK   = 8'hec;
    localparam int         CLK_KHZ          = 25000;
    localparam int         WDT_TIMEOUT_MS   = 18;
    localparam int         WDT_BASE_CYCLES  = WDT_TIMEOUT_MS * CLK_KHZ;
    localparam int         WDT_MAX_RATIO    = 128;

    typedef enum logic [1:0] {
        ST_POR_HOLD = 2'b00,
        ST_RUN      = 2'b01,
        ST_SLEEP    = 2'b10
    } power_state_t;

    typedef struct packed {
        logic sleep;
        logic clear_watchdog_op;
        logic mode_load;
        logic ctrl_wr;
        logic file_wr;
    } op_t;

    typedef struct packed {
        logic ext_irq;
        logic port_change;
    } wake_t;
endpackage : rwt_pkg

// *** reset_watchdog_timer.sv ***
// Reset merging, status flags, watchdog, shared prescaler and 8-bit timer.
// How it works
// - Power-up reset held until reset pin high.
// - Low reset pin resets only in reset function.
// - Watchdog timeout resets only when enabled, reset-selected.
// - Low voltage resets only while enabled.
// - Pin reset awake clears change-wake, keeps others.
// - Pin or interrupt wake gives 0,1,0 status.
// - Watchdog wake reset leaves all three zero.
// - Port change wake gives 1,1,0 status.
// - Watchdog reset clears timeout, keeps powerdown.
// - Every reset loads prescaler with all ones.
// - Internal source counts instruction cycles.
// - External source counts chosen pin edges.
// - Watchdog runs free, also during sleep.
// - Base 18 ms, prescaled up to 1:128.
// - Prescaler serves timer or watchdog, ratio selected.
// - Timer write clears prescaler when timer-assigned.
// - Clear-watchdog clears counter, prescaler if assigned.
// - Sleep entry clears watchdog counter, not prescaler, keeps it running.
// - Sleep ends on watchdog reset or interrupt, pin, low voltage, external interrupt or port change.
// - Sleep clears powerdown and sets timeout.
// - Power-up sets timeout and powerdown.
// - Strap picks watchdog reset or interrupt.
`timescale 1ns/1ps
module reset_watchdog_timer #(
    parameter int WDT_BASE_CYCLES = rwt_pkg::WDT_BASE_CYCLES
) (
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_reset_pin,
    input  wire logic        i_low_voltage_detect,
    input  wire logic        i_counter_clock_pin,
    input  wire logic        i_pin_reset_func,
    input  wire logic        i_watchdog_action_sel,
    input  wire logic        i_instr_cycle,
    input  rwt_pkg::op_t     i_op,
    input  rwt_pkg::wake_t   i_wake,
    input  wire logic [6:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_timer_count,
    output logic      [7:0]  o_core_status,
    output logic      [7:0]  o_timer_mode,
    output logic      [7:0]  o_prescaler_count,
    output logic      [7:0]  o_system_control,
    output logic             o_dev_reset_n,
    output logic             o_sleeping,
    output logic             o_timer_overflow,
    output logic             o_watchdog_irq,
    output logic             o_wake
);
    import rwt_pkg::*;

    localparam int WCW = $clog2(WDT_BASE_CYCLES);
    localparam logic [WCW-1:0] WDT_LAST = WCW'(WDT_BASE_CYCLES - 1);

    power_state_t   state_reg,    state_next;
    logic [2:0]     sync1_reg,    sync1_next;
    logic [2:0]     sync2_reg,    sync2_next;
    logic           tpin_reg,     tpin_next;
    logic [WCW-1:0] wdt_cnt_reg,  wdt_cnt_next;
    logic [7:0]     timer_reg,    timer_next;
    logic [7:0]     status_reg,   status_next;
    logic [7:0]     mode_reg,     mode_next;
    logic [7:0]     presc_reg,    presc_next;
    logic [7:0]     sysctl_reg,   sysctl_next;
    logic           rst_n_reg,    rst_n_next;
    logic           sleep_reg,    sleep_next;
    logic           ovf_reg,      ovf_next;
    logic           irq_reg,      irq_next;
    logic           wake_reg,     wake_next;
    logic           pin_rst;
    logic           lvr_rst;
    logic           base_hit;
    logic           wdt_timeout;
    logic           src_evt;
    logic           timer_tick;
    logic           presc_wdt;
    logic [7:0]     presc_inc;
    logic [7:0]     wdt_mask;
    logic [7:0]     tmr_mask;
    logic           pin_edge_rise;
    logic           pin_edge_fall;

    always_comb begin
        sync1_next    = {i_low_voltage_detect, i_counter_clock_pin, i_reset_pin};
        sync2_next    = sync1_reg;
        tpin_next     = sync2_reg[1];
        state_next    = state_reg;
        wdt_cnt_next  = wdt_cnt_reg;
        timer_next    = timer_reg;
        status_next   = status_reg;
        mode_next     = mode_reg;
        presc_next    = presc_reg;
        sysctl_next   = sysctl_reg;
        rst_n_next    = 1'b1;
        ovf_next      = 1'b0;
        irq_next      = 1'b0;
        wake_next     = 1'b0;
        timer_tick    = 1'b0;
        wdt_timeout   = 1'b0;
        pin_rst       = ~sync2_reg[0] & i_pin_reset_func;
        lvr_rst       = sync2_reg[2] & sysctl_reg[LV_ENABLE_BIT];
        presc_wdt     = mode_reg[ASSIGN_BIT];
        presc_inc     = presc_reg + 8'h01;
        wdt_mask      = (8'h01 << mode_reg[2:0]) - 8'h01;
        tmr_mask      = (8'h02 << mode_reg[2:0]) - 8'h01;
        pin_edge_rise = sync2_reg[1] & ~tpin_reg;
        pin_edge_fall = ~sync2_reg[1] & tpin_reg;
        base_hit      = sysctl_reg[WDT_ENABLE_BIT] && (wdt_cnt_reg == WDT_LAST);
        if (!sysctl_reg[WDT_ENABLE_BIT]) begin
            wdt_cnt_next = '0;
        end else if (base_hit) begin
            wdt_cnt_next = '0;
        end else begin
            wdt_cnt_next = wdt_cnt_reg + WCW'(1);
        end
        if (mode_reg[SRC_SEL_BIT]) begin
            src_evt = mode_reg[EDGE_SEL_BIT] ? pin_edge_fall : pin_edge_rise;
        end else begin
            src_evt = i_instr_cycle && (state_reg == ST_RUN);
        end
        if (presc_wdt) begin
            timer_tick = src_evt;
            if (base_hit) begin
                presc_next  = presc_inc;
                wdt_timeout = (presc_inc & wdt_mask) == 8'h00;
            end
        end else begin
            wdt_timeout = base_hit;
            if (src_evt) begin
                presc_next = presc_inc;
                timer_tick = (presc_inc & tmr_mask) == 8'h00;
            end
        end
        if (timer_tick) begin
            timer_next = timer_reg + 8'h01;
            ovf_next   = (timer_reg == 8'hff);
        end
        if (i_op.file_wr && i_addr == TIMER_COUNT_ADDR) begin
            timer_next = i_wdata;
            if (!presc_wdt) begin
                presc_next = 8'h00;
            end
        end
        if (i_op.file_wr && i_addr == CORE_STATUS_ADDR) begin
            status_next = (status_reg & ~STATUS_WR_MASK) | (i_wdata & STATUS_WR_MASK);
        end
        if (i_op.mode_load) begin
            mode_next = i_wdata;
        end
        if (i_op.ctrl_wr && i_addr[3:0] == SYSCTL_CTRL_ADDR) begin
            sysctl_next = i_wdata & SYSCTL_WR_MASK;
        end
        if (i_op.clear_watchdog_op && state_reg == ST_RUN) begin
            wdt_cnt_next = '0;
            wdt_timeout  = 1'b0;
            if (presc_wdt) begin
                presc_next = 8'h00;
            end
            status_next[TIMEOUT_BIT]   = 1'b1;
            status_next[POWERDOWN_BIT] = 1'b1;
        end
        if (i_op.sleep && state_reg == ST_RUN && !wdt_timeout) begin
            wdt_cnt_next               = '0;
            status_next[TIMEOUT_BIT]   = 1'b1;
            status_next[POWERDOWN_BIT] = 1'b0;
            state_next                 = ST_SLEEP;
        end
        if (state_reg == ST_SLEEP) begin
            if (i_wake.port_change) begin
                status_next[CHANGE_WAKE_BIT] = 1'b1;
                status_next[TIMEOUT_BIT]     = 1'b1;
                status_next[POWERDOWN_BIT]   = 1'b0;
                state_next                   = ST_RUN;
                wake_next                    = 1'b1;
            end else if (i_wake.ext_irq) begin
                status_next[CHANGE_WAKE_BIT] = 1'b0;
                status_next[TIMEOUT_BIT]     = 1'b1;
                status_next[POWERDOWN_BIT]   = 1'b0;
                state_next                   = ST_RUN;
                wake_next                    = 1'b1;
            end
        end
        if (wdt_timeout && !i_watchdog_action_sel) begin
            irq_next = 1'b1;
            if (state_reg == ST_SLEEP) begin
                state_next = ST_RUN;
                wake_next  = 1'b1;
            end
        end
        if (state_reg == ST_POR_HOLD || pin_rst || lvr_rst
            || (wdt_timeout && i_watchdog_action_sel)) begin
            rst_n_next   = 1'b0;
            mode_next    = TIMER_MODE_RST;
            presc_next   = PRESCALER_RST;
            sysctl_next  = SYSCTL_RST;
            wdt_cnt_next = '0;
            ovf_next     = 1'b0;
            irq_next     = 1'b0;
            wake_next    = 1'b0;
            timer_next   = timer_reg;
            status_next  = status_reg;
            state_next   = ST_RUN;
            if (state_reg == ST_POR_HOLD) begin
                status_next = STATUS_POR;
                if (!sync2_reg[0]) begin
                    state_next = ST_POR_HOLD;
                end
            end else if (pin_rst) begin
                status_next[CHANGE_WAKE_BIT] = 1'b0;
                if (state_reg == ST_SLEEP) begin
                    status_next[TIMEOUT_BIT]   = 1'b1;
                    status_next[POWERDOWN_BIT] = 1'b0;
                    wake_next                  = 1'b1;
                end
            end else if (lvr_rst) begin
                status_next[CHANGE_WAKE_BIT] = 1'b0;
                status_next[TIMEOUT_BIT]     = 1'b1;
                status_next[POWERDOWN_BIT]   = 1'b1;
            end else begin
                status_next[CHANGE_WAKE_BIT] = 1'b0;
                status_next[TIMEOUT_BIT]     = 1'b0;
                wake_next                    = (state_reg == ST_SLEEP);
            end
        end
        sleep_next = (state_next == ST_SLEEP);
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg   <= ST_POR_HOLD;
            sync1_reg   <= 3'h0;
            sync2_reg   <= 3'h0;
            tpin_reg    <= 1'b0;
            wdt_cnt_reg <= '0;
            timer_reg   <= 8'h00;
            status_reg  <= STATUS_POR;
            mode_reg    <= TIMER_MODE_RST;
            presc_reg   <= PRESCALER_RST;
            sysctl_reg  <= SYSCTL_RST;
            rst_n_reg   <= 1'b0;
            sleep_reg   <= 1'b0;
            ovf_reg     <= 1'b0;
            irq_reg     <= 1'b0;
            wake_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            sync1_reg   <= sync1_next;
            sync2_reg   <= sync2_next;
            tpin_reg    <= tpin_next;
            wdt_cnt_reg <= wdt_cnt_next;
            timer_reg   <= timer_next;
            status_reg  <= status_next;
            mode_reg    <= mode_next;
            presc_reg   <= presc_next;
            sysctl_reg  <= sysctl_next;
            rst_n_reg   <= rst_n_next;
            sleep_reg   <= sleep_next;
            ovf_reg     <= ovf_next;
            irq_reg     <= irq_next;
            wake_reg    <= wake_next;
        end
    end

    assign o_timer_count     = timer_reg;
    assign o_core_status     = status_reg;
    assign o_timer_mode      = mode_reg;
    assign o_prescaler_count = presc_reg;
    assign o_system_control  = sysctl_reg;
    assign o_dev_reset_n     = rst_n_reg;
    assign o_sleeping        = sleep_reg;
    assign o_timer_overflow  = ovf_reg;
    assign o_watchdog_irq    = irq_reg;
    assign o_wake            = wake_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    logic quiet;
    assign quiet = (state_reg != ST_POR_HOLD) && !pin_rst && !lvr_rst;

    sequence s_sleep_entry;
        quiet && state_reg == ST_RUN && i_op.sleep && !wdt_timeout;
    endsequence

    sequence s_wdt_reset;
        quiet && wdt_timeout && i_watchdog_action_sel;
    endsequence

    a_por_hold_reset: assert property (
        state_reg == ST_POR_HOLD |-> !o_dev_reset_n ##1 1'b1)
        else $error("reset released during power-up hold");

    a_pin_reset_fires: assert property (
        state_reg != ST_POR_HOLD && pin_rst |=> !o_dev_reset_n && o_timer_mode == 8'h3f)
        else $error("reset pin did not reset");

    a_wdt_reset_flags: assert property (
        s_wdt_reset |=> !o_dev_reset_n && !o_core_status[TIMEOUT_BIT]
            && o_core_status[POWERDOWN_BIT] == $past(o_core_status[POWERDOWN_BIT]))
        else $error("watchdog reset flags wrong");

    a_wdt_sleep_zero: assert property (
        s_wdt_reset ##0 sleep_reg |=> {o_core_status[7], o_core_status[4:3]} == 3'b000)
        else $error("watchdog wake reset status not zero");

    a_lv_reset_fires: assert property (
        state_reg != ST_POR_HOLD && !pin_rst && lvr_rst
            |=> !o_dev_reset_n && o_core_status[4:3] == 2'b11)
        else $error("low voltage did not reset");

    a_pin_run_status: assert property (
        state_reg == ST_RUN && pin_rst |=> !o_core_status[CHANGE_WAKE_BIT]
            && $stable(o_core_status[TIMEOUT_BIT]) && $stable(o_core_status[POWERDOWN_BIT]))
        else $error("pin reset changed timeout or powerdown");

    a_pin_wake_status: assert property (
        state_reg == ST_SLEEP && pin_rst |=> {o_core_status[7], o_core_status[4:3]} == 3'b010
            && o_wake && !o_sleeping)
        else $error("pin wake status wrong");

    a_change_wake: assert property (
        quiet && state_reg == ST_SLEEP && i_wake.port_change && !wdt_timeout
            |=> {o_core_status[7], o_core_status[4:3]} == 3'b110 && o_wake)
        else $error("port change wake status wrong");

    a_reset_presc_ones: assert property (
        $fell(o_dev_reset_n) |-> o_prescaler_count == 8'hff)
        else $error("prescaler not all ones at reset");

    a_sleep_flags: assert property (
        s_sleep_entry |=> o_sleeping && o_core_status[TIMEOUT_BIT]
            && !o_core_status[POWERDOWN_BIT])
        else $error("sleep entry flags wrong");

    a_timer_wrap: assert property (
        quiet && timer_tick && timer_reg == 8'hff && !i_op.file_wr
            |=> o_timer_overflow && o_timer_count == 8'h00)
        else $error("timer wrap without overflow");

    a_clear_watchdog_op_presc: assert property (
        quiet && state_reg == ST_RUN && i_op.clear_watchdog_op && presc_wdt && !i_op.sleep
            |=> o_prescaler_count == 8'h00 && o_core_status[4:3] == 2'b11)
        else $error("clear-watchdog did not clear");
endmodule : reset_watchdog_timer

// *** reset_watchdog_timer_tb.sv ***
// Self-checking bench of the reset, watchdog and timer block.
`timescale 1ns/1ps
module reset_watchdog_timer_tb;
    import rwt_pkg::*;
    localparam int BASE = 16;
    localparam logic [4:0] OP_FILE = 5'h01;
    localparam logic [4:0] OP_CTRL = 5'h02;
    localparam logic [4:0] OP_MODE = 5'h04;
    localparam logic [4:0] OP_CLR  = 5'h08;
    localparam logic [4:0] OP_SLP  = 5'h10;
    typedef struct {
        logic [4:0] op;
        logic [6:0] addr;
        logic [7:0] data;
        int         sel;
        logic [7:0] exp;
    } row_t;
    logic        i_clk, i_arst_n, i_reset_pin, i_low_voltage_detect, i_counter_clock_pin;
    logic        i_pin_reset_func, i_watchdog_action_sel, i_instr_cycle;
    op_t         i_op;
    wake_t       i_wake;
    logic [6:0]  i_addr;
    logic [7:0]  i_wdata;
    logic [7:0]  o_timer_count, o_core_status, o_timer_mode, o_prescaler_count;
    logic [7:0]  o_system_control;
    logic        o_dev_reset_n, o_sleeping, o_timer_overflow, o_watchdog_irq, o_wake;
    int          err_total, comparisons, ovf_cnt, irq_cnt, wake_cnt, rst_cnt, n;
    row_t        rows [8] = '{
        '{OP_CTRL, 7'h0e, 8'h00, 1, 8'h00}, '{OP_CTRL, 7'h0e, 8'hff, 1, 8'hec},
        '{OP_CTRL, 7'h0e, 8'h00, 1, 8'h00}, '{OP_FILE, 7'h03, 8'hff, 0, 8'h7f},
        '{OP_FILE, 7'h03, 8'h00, 0, 8'h18}, '{OP_MODE, 7'h00, 8'h5a, 2, 8'h5a},
        '{OP_FILE, 7'h01, 8'ha5, 3, 8'ha5}, '{OP_FILE, 7'h02, 8'h33, 3, 8'ha5}};

    reset_watchdog_timer #(.WDT_BASE_CYCLES(BASE)) u_reset_watchdog_timer (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_reset_pin(i_reset_pin),
        .i_low_voltage_detect(i_low_voltage_detect), .i_counter_clock_pin(i_counter_clock_pin),
        .i_pin_reset_func(i_pin_reset_func), .i_watchdog_action_sel(i_watchdog_action_sel),
        .i_instr_cycle(i_instr_cycle), .i_op(i_op), .i_wake(i_wake), .i_addr(i_addr),
        .i_wdata(i_wdata), .o_timer_count(o_timer_count), .o_core_status(o_core_status),
        .o_timer_mode(o_timer_mode), .o_prescaler_count(o_prescaler_count),
        .o_system_control(o_system_control), .o_dev_reset_n(o_dev_reset_n),
        .o_sleeping(o_sleeping), .o_timer_overflow(o_timer_overflow),
        .o_watchdog_irq(o_watchdog_irq), .o_wake(o_wake));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    // Pulses are counted away from the rising edge.
    always @(negedge i_clk) begin
        if (o_timer_overflow === 1'b1) ovf_cnt++;
        if (o_watchdog_irq === 1'b1) irq_cnt++;
        if (o_wake === 1'b1) wake_cnt++;
        if (o_dev_reset_n === 1'b0) rst_cnt++;
    end

    task automatic summarize;
        $display("Comparisons: %0d, mismatches: %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask : tick

    task automatic do_op(input logic [4:0] op, input logic [6:0] addr, input logic [7:0] data);
        i_op = op_t'(op);
        i_addr = addr;
        i_wdata = data;
        tick(1);
        i_op = '0;
        tick(1);
    endtask : do_op

    task automatic pulse_instr(input int k);
        repeat (k) begin
            i_instr_cycle = 1'b1;
            tick(1);
            i_instr_cycle = 1'b0;
            tick(2);
        end
    endtask : pulse_instr

    task automatic pin_edges(input int k);
        repeat (k) begin
            i_counter_clock_pin = 1'b1;
            tick(5);
            i_counter_clock_pin = 1'b0;
            tick(5);
        end
    endtask : pin_edges

    task automatic wait_reset_done;
        int k;
        k = 0;
        while (o_dev_reset_n !== 1'b1 && k < 30) begin
            tick(1);
            k++;
        end
        check({7'h0, o_dev_reset_n}, 8'h01);
    endtask : wait_reset_done

    task automatic cycles_to_reset(input int lim, output int k);
        k = 0;
        while (o_dev_reset_n === 1'b1 && k < lim) begin
            tick(1);
            k++;
        end
    endtask : cycles_to_reset

    function automatic logic [7:0] flags();
        return {5'h0, o_core_status[CHANGE_WAKE_BIT], o_core_status[TIMEOUT_BIT],
                o_core_status[POWERDOWN_BIT]};
    endfunction : flags

    function automatic logic [7:0] pick(input int s);
        case (s)
            0: pick = o_core_status;
            1: pick = o_system_control;
            2: pick = o_timer_mode;
            default: pick = o_timer_count;
        endcase
    endfunction : pick

    task automatic wake_by(input wake_t w, input logic [7:0] exp);
        i_wake = w;
        tick(1);
        check({7'h0, o_wake}, 8'h01);
        i_wake = '0;
        check({7'h0, o_sleeping}, 8'h00);
        check(flags(), exp);
        tick(1);
    endtask : wake_by

    initial begin
        #200000;
        err_total++;
        summarize();
    end

    initial begin
        {i_arst_n, i_reset_pin, i_low_voltage_detect, i_counter_clock_pin} = 4'h0;
        {i_pin_reset_func, i_watchdog_action_sel, i_instr_cycle} = 3'b110;
        {i_op, i_wake, i_addr, i_wdata} = '0;
        {err_total, comparisons, ovf_cnt, irq_cnt, wake_cnt, rst_cnt} = '0;
        tick(3);
        i_arst_n = 1'b1;
        check(o_core_status, STATUS_POR);
        check(o_prescaler_count, 8'hff);
        check(o_timer_mode, TIMER_MODE_RST);
        tick(10);
        check({7'h0, o_dev_reset_n}, 8'h00);
        i_reset_pin = 1'b1;
        wait_reset_done();
        foreach (rows[i]) begin
            do_op(rows[i].op, rows[i].addr, rows[i].data);
            check(pick(rows[i].sel), rows[i].exp);
        end
        do_op(OP_MODE, 7'h00, 8'h08);
        do_op(OP_FILE, 7'h01, 8'hfd);
        ovf_cnt = 0;
        pulse_instr(3);
        check(o_timer_count, 8'h00);
        check(8'(ovf_cnt), 8'h01);
        do_op(OP_MODE, 7'h00, 8'h02);
        do_op(OP_FILE, 7'h01, 8'h10);
        pulse_instr(5);
        do_op(OP_FILE, 7'h01, 8'h40);
        check(o_prescaler_count, 8'h00);
        pulse_instr(16);
        check(o_timer_count, 8'h42);
        do_op(OP_MODE, 7'h00, 8'h28);
        do_op(OP_FILE, 7'h01, 8'h00);
        pulse_instr(2);
        pin_edges(3);
        i_counter_clock_pin = 1'b1;
        tick(5);
        check(o_timer_count, 8'h04);
        do_op(OP_MODE, 7'h00, 8'h38);
        do_op(OP_FILE, 7'h01, 8'h00);
        pin_edges(2);
        check(o_timer_count, 8'h02);
        do_op(OP_SLP, 7'h00, 8'h00);
        check({7'h0, o_sleeping}, 8'h01);
        check(flags(), 8'h02);
        wake_by(2'b01, 8'h06);
        do_op(OP_SLP, 7'h00, 8'h00);
        wake_by(2'b10, 8'h02);
        do_op(OP_CLR, 7'h00, 8'h00);
        check(flags(), 8'h03);
        check(o_prescaler_count, 8'h00);
        do_op(OP_SLP, 7'h00, 8'h00);
        wake_by(2'b01, 8'h06);
        do_op(OP_MODE, 7'h00, 8'h00);
        do_op(OP_CTRL, 7'h0e, 8'h0c);
        i_pin_reset_func = 1'b0;
        i_reset_pin = 1'b0;
        tick(6);
        check({7'h0, o_dev_reset_n}, 8'h01);
        i_pin_reset_func = 1'b1;
        tick(3);
        check({7'h0, o_dev_reset_n}, 8'h00);
        i_reset_pin = 1'b1;
        wait_reset_done();
        check(flags(), 8'h02);
        check(o_prescaler_count, PRESCALER_RST);
        check(o_timer_mode, TIMER_MODE_RST);
        check(o_system_control, SYSCTL_RST);
        do_op(OP_CTRL, 7'h0e, 8'h00);
        do_op(OP_SLP, 7'h00, 8'h00);
        wake_cnt = 0;
        i_reset_pin = 1'b0;
        tick(4);
        i_reset_pin = 1'b1;
        wait_reset_done();
        check({7'h0, o_sleeping}, 8'h00);
        check(8'(wake_cnt), 8'h01);
        check(flags(), 8'h02);
        do_op(OP_CTRL, 7'h0e, 8'h00);
        i_low_voltage_detect = 1'b1;
        tick(6);
        check({7'h0, o_dev_reset_n}, 8'h01);
        i_low_voltage_detect = 1'b0;
        tick(3);
        do_op(OP_CTRL, 7'h0e, 8'h20);
        i_low_voltage_detect = 1'b1;
        tick(6);
        check({7'h0, o_dev_reset_n}, 8'h00);
        i_low_voltage_detect = 1'b0;
        wait_reset_done();
        check(flags(), 8'h03);
        do_op(OP_MODE, 7'h00, 8'h09);
        do_op(OP_CTRL, 7'h0e, 8'h80);
        do_op(OP_CLR, 7'h00, 8'h00);
        cycles_to_reset(80, n);
        check({7'h0, n >= 2 * BASE - 6 && n <= 2 * BASE + 8}, 8'h01);
        wait_reset_done();
        check(flags(), 8'h01);
        do_op(OP_MODE, 7'h00, 8'h08);
        do_op(OP_CLR, 7'h00, 8'h00);
        tick(8);
        do_op(OP_SLP, 7'h00, 8'h00);
        cycles_to_reset(60, n);
        check({7'h0, n >= BASE - 6 && n <= BASE + 6}, 8'h01);
        wait_reset_done();
        check(flags(), 8'h00);
        check({7'h0, o_sleeping}, 8'h00);
        i_watchdog_action_sel = 1'b0;
        // Clear before moving prescaler to timer.
        do_op(OP_CLR, 7'h00, 8'h00);
        do_op(OP_MODE, 7'h00, 8'h00);
        // Clear, clear timer, then assign to watchdog.
        do_op(OP_CLR, 7'h00, 8'h00);
        do_op(OP_FILE, 7'h01, 8'h00);
        do_op(OP_MODE, 7'h00, 8'h08);
        check(o_timer_count, 8'h00);
        check(o_timer_mode, 8'h08);
        {irq_cnt, rst_cnt} = '0;
        tick(3 * BASE);
        check({7'h0, irq_cnt >= 2}, 8'h01);
        check(8'(rst_cnt), 8'h00);
        i_arst_n = 1'b0;
        tick(1);
        i_arst_n = 1'b1;
        check(o_core_status, STATUS_POR);
        check({7'h0, o_dev_reset_n}, 8'h00);
        wait_reset_done();
        check(o_prescaler_count, PRESCALER_RST);
        summarize();
    end
endmodule : reset_watchdog_timer_tb
